// ===== rtl/dtc_cfg.svh
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL    8'h88
`define DTC_IDX_TIMER_MODE_SELECT    8'h89
`define DTC_IDX_TL0     8'h8a
`define DTC_IDX_TL1     8'h8b
`define DTC_IDX_TH0     8'h8c
`define DTC_IDX_TH1     8'h8d
`define DTC_IDX_ISTAT   8'h90
`define DTC_IDX_IMASK   8'h91
// Unused upper address bits above the index
`define DTC_ADDR_PAD    2'h0

// Control register bit positions
`define DTC_TF1         7
`define DTC_TR1         6
`define DTC_TF0         5
`define DTC_TR0         4

// Mode register nibble layout (timer 1 in the upper nibble)
`define DTC_T1_SHIFT    4
`define DTC_GATE        3
`define DTC_SRC         2

// Mode field codes
`define DTC_MODE_13     2'h0
`define DTC_MODE_16     2'h1
`define DTC_MODE_RLD    2'h2
`define DTC_MODE_SPLIT  2'h3

// Reset values
`define DTC_RST_BYTE    8'h00
`define DTC_RST_MC      4'h0

// Machine cycle: twelve oscillator periods, the oscillator being sys_clk
`define DTC_OSC_PER_MC  4'hc
`define DTC_MC_LAST     (`DTC_OSC_PER_MC - 4'h1)
// Last value of the 5-bit prescaler
`define DTC_PRE_MAX     5'h1f

// Bus responses
`define DTC_RESP_OK     2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// ===== rtl/dtc_pkg.sv
package dtc_pkg;

	// Bus requests from the master
	typedef struct packed {
		logic [11:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [11:0] araddr;
		logic        arvalid;
		logic        rready;
	} dtc_axi_req_s;

	// Bus answers to the master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} dtc_axi_rsp_s;

	// External pins, index 0 for timer 0, index 1 for timer 1
	typedef struct packed {
		logic [1:0] count_pin;
		logic [1:0] ext_gate_pin;
	} dtc_pin_s;

	// Result of one counting step
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic       ovf;
	} dtc_cnt_s;

	// Complete state of the unit
	typedef struct packed {
		logic [7:0]  tl0;
		logic [7:0]  th0;
		logic [7:0]  tl1;
		logic [7:0]  th1;
		logic [7:0]  timer_run_overflow_control;
		logic [7:0]  timer_mode_select;
		logic [1:0]  istat;
		logic [1:0]  imask;
		logic [3:0]  mc_cnt;
		logic [1:0]  cnt_s1;
		logic [1:0]  cnt_s2;
		logic [1:0]  cnt_prev;
		logic [1:0]  gate_s1;
		logic [1:0]  gate_s2;
		logic        aw_got;
		logic [11:0] awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dtc_state_s;

endpackage

// ===== rtl/dtc_top.sv
// Operation
// - Mode 0: high byte behind 5-bit prescaler
// - Mode 1: bytes cascaded into 16 bits
// - Mode 2: low byte reloads from high byte
// - Split mode: timer 0 low byte independent
// - Split mode: high byte uses timer 1 run/flag
// - Timer 1 in split mode holds count
// - Run bit starts and stops each timer
// - Overflow sets the timer's flag; timer 1 sets none while timer 0 is in split mode
// - Interrupt vectoring clears the overflow flag
// - Gate bit requires gate pin high too
// - Source bit picks pin events or clock
// - Mode register: timer 1 upper nibble
// - Control register: flags and runs upper nibble
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dtc_cfg.svh"

module dtc_top (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire dtc_pkg::dtc_axi_req_s axi_req,
	output var dtc_pkg::dtc_axi_rsp_s axi_rsp,
	input  wire dtc_pkg::dtc_pin_s     pins,
	input  wire logic [1:0]       int_ack,
	output logic [1:0]            ovf_req,
	output logic                  irq
);

	dtc_pkg::dtc_state_s st_ff;      // Registered state
	dtc_pkg::dtc_state_s nxt_st;     // Next state
	logic                mc_tick;    // One pulse per machine cycle
	logic [1:0]          fall;       // Falling edge seen on a count pin
	logic [1:0]          m0;         // Timer 0 mode field
	logic [1:0]          m1;         // Timer 1 mode field
	logic                en0;        // Timer 0 enabled by run and gate
	logic                en1;        // Timer 1 enabled by run and gate
	logic                tick0;      // Timer 0 count pulse
	logic                tick1;      // Timer 1 count pulse
	logic                ovf0_ev;    // Timer 0 overflow event
	logic                ovf1_ev;    // Event for the timer 1 flag
	logic                wr_en;      // Register write performed this cycle
	logic [9:0]          widx;       // Write index with padding
	logic                wr_cnt0;    // Software writes a timer 0 byte
	logic                wr_cnt1;    // Software writes a timer 1 byte
	logic                wr_timer_run_overflow_control;    // Software writes the control register

	// One counting step of a timer in the given mode
	function automatic dtc_pkg::dtc_cnt_s step(
		input logic [1:0] mode,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic       inc
	);
		dtc_pkg::dtc_cnt_s r;
		r.lo  = lo;
		r.hi  = hi;
		r.ovf = 1'b0;
		if (inc) begin
			case (mode)
				`DTC_MODE_13: begin
					// Low five bits divide by 32, carry clocks the high byte
					r.lo = {lo[7:5], lo[4:0] + 5'h01};
					if (lo[4:0] == `DTC_PRE_MAX) begin
						r.hi  = hi + 8'h01;
						r.ovf = (hi == 8'hff);
					end
				end
				`DTC_MODE_16: begin
					{r.hi, r.lo} = {hi, lo} + 16'h0001;
					r.ovf        = ({hi, lo} == 16'hffff);
				end
				`DTC_MODE_RLD: begin
					// Reload keeps the period fixed without software help
					if (lo == 8'hff) begin
						r.lo  = hi;
						r.ovf = 1'b1;
					end else begin
						r.lo = lo + 8'h01;
					end
				end
				default: begin
					// Split mode: the low byte alone counts
					r.lo  = lo + 8'h01;
					r.ovf = (lo == 8'hff);
				end
			endcase
		end
		return r;
	endfunction

	// Whole next-state logic of the unit
	always_comb begin
		dtc_pkg::dtc_cnt_s r0;
		dtc_pkg::dtc_cnt_s r1;
		dtc_pkg::dtc_cnt_s rh;
		logic [9:0]        ridx;
		logic [7:0]        rbyte;
		logic              rhit;
		r0     = '0;
		r1     = '0;
		rh     = '0;
		ridx   = '0;
		rbyte  = `DTC_RST_BYTE;
		rhit   = 1'b0;
		nxt_st = st_ff;

		// Pins pass two flops before any logic reads them
		nxt_st.cnt_s1  = pins.count_pin;
		nxt_st.cnt_s2  = st_ff.cnt_s1;
		nxt_st.gate_s1 = pins.ext_gate_pin;
		nxt_st.gate_s2 = st_ff.gate_s1;

		// Machine cycle divider
		mc_tick       = (st_ff.mc_cnt == `DTC_MC_LAST);
		nxt_st.mc_cnt = mc_tick ? `DTC_RST_MC : st_ff.mc_cnt + 4'h1;

		// Count pins are sampled once per machine cycle; a pulse shorter
		// than one machine cycle may be missed
		if (mc_tick) begin
			nxt_st.cnt_prev = st_ff.cnt_s2;
		end
		fall = {2{mc_tick}} & st_ff.cnt_prev & ~st_ff.cnt_s2;

		// Mode register fields
		m0  = st_ff.timer_mode_select[1:0];
		m1  = st_ff.timer_mode_select[`DTC_T1_SHIFT+1:`DTC_T1_SHIFT];
		en0 = st_ff.timer_run_overflow_control[`DTC_TR0] &
			(!st_ff.timer_mode_select[`DTC_GATE] | st_ff.gate_s2[0]);
		en1 = st_ff.timer_run_overflow_control[`DTC_TR1] &
			(!st_ff.timer_mode_select[`DTC_T1_SHIFT+`DTC_GATE] | st_ff.gate_s2[1]);
		tick0 = en0 & (st_ff.timer_mode_select[`DTC_SRC] ? fall[0] : mc_tick);
		tick1 = en1 & (m1 != `DTC_MODE_SPLIT) &
			(st_ff.timer_mode_select[`DTC_T1_SHIFT+`DTC_SRC] ? fall[1] : mc_tick);

		// Counting steps
		r0 = step(m0, st_ff.tl0, st_ff.th0, tick0);
		r1 = step(m1, st_ff.tl1, st_ff.th1, tick1);
		if (m0 == `DTC_MODE_SPLIT) begin
			// High byte of timer 0 is a plain timer run by timer 1's bit
			rh = step(`DTC_MODE_SPLIT, st_ff.th0, st_ff.th0,
				mc_tick & st_ff.timer_run_overflow_control[`DTC_TR1]);
			r0.hi = rh.lo;
		end
		ovf0_ev = r0.ovf;
		// Timer 1 loses its flag to timer 0's high byte in split mode
		ovf1_ev = (m0 == `DTC_MODE_SPLIT) ? rh.ovf : r1.ovf;
		nxt_st.tl0 = r0.lo;
		nxt_st.th0 = r0.hi;
		nxt_st.tl1 = r1.lo;
		nxt_st.th1 = r1.hi;

		// Write path: address and data are taken in either order
		if (axi_req.awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = axi_req.wdata;
			nxt_st.wstrb = axi_req.wstrb;
		end
		wr_en   = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
		widx    = st_ff.awaddr[11:2];
		wr_cnt0 = 1'b0;
		wr_cnt1 = 1'b0;
		wr_timer_run_overflow_control = 1'b0;

		// Vectoring clears the flag; software write next; events last
		if (int_ack[0]) begin
			nxt_st.timer_run_overflow_control[`DTC_TF0] = 1'b0;
		end
		if (int_ack[1]) begin
			nxt_st.timer_run_overflow_control[`DTC_TF1] = 1'b0;
		end
		if (wr_en) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = `DTC_RESP_OK;
			case (widx)
				{`DTC_ADDR_PAD, `DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL}: begin
					wr_timer_run_overflow_control = st_ff.wstrb[0];
					if (wr_timer_run_overflow_control) begin
						// Low nibble is kept as plain storage for other logic
						nxt_st.timer_run_overflow_control = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_TIMER_MODE_SELECT}: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.timer_mode_select = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_TL0}: begin
					wr_cnt0 = st_ff.wstrb[0];
					if (wr_cnt0) begin
						nxt_st.tl0 = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_TH0}: begin
					wr_cnt0 = st_ff.wstrb[0];
					if (wr_cnt0) begin
						nxt_st.th0 = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_TL1}: begin
					wr_cnt1 = st_ff.wstrb[0];
					if (wr_cnt1) begin
						nxt_st.tl1 = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_TH1}: begin
					wr_cnt1 = st_ff.wstrb[0];
					if (wr_cnt1) begin
						nxt_st.th1 = st_ff.wdata[7:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_ISTAT}: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.istat = st_ff.istat & ~st_ff.wdata[1:0];
					end
				end
				{`DTC_ADDR_PAD, `DTC_IDX_IMASK}: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.imask = st_ff.wdata[1:0];
					end
				end
				default: begin
					// Unmapped address
					nxt_st.bresp = `DTC_RESP_SLVERR;
				end
			endcase
		end else if (st_ff.bvalid && axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// Hardware set wins over any clear in the same cycle
		if (ovf0_ev) begin
			nxt_st.timer_run_overflow_control[`DTC_TF0] = 1'b1;
		end
		if (ovf1_ev) begin
			nxt_st.timer_run_overflow_control[`DTC_TF1] = 1'b1;
		end
		nxt_st.istat = nxt_st.istat | {ovf1_ev, ovf0_ev};

		// Read path: one read under way, answered the cycle after it is taken
		if (axi_req.arvalid && !st_ff.rvalid) begin
			ridx = axi_req.araddr[11:2];
			rhit = 1'b1;
			case (ridx)
				{`DTC_ADDR_PAD, `DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL}:  rbyte = st_ff.timer_run_overflow_control;
				{`DTC_ADDR_PAD, `DTC_IDX_TIMER_MODE_SELECT}:  rbyte = st_ff.timer_mode_select;
				{`DTC_ADDR_PAD, `DTC_IDX_TL0}:   rbyte = st_ff.tl0;
				{`DTC_ADDR_PAD, `DTC_IDX_TH0}:   rbyte = st_ff.th0;
				{`DTC_ADDR_PAD, `DTC_IDX_TL1}:   rbyte = st_ff.tl1;
				{`DTC_ADDR_PAD, `DTC_IDX_TH1}:   rbyte = st_ff.th1;
				{`DTC_ADDR_PAD, `DTC_IDX_ISTAT}: rbyte = {6'h00, st_ff.istat};
				{`DTC_ADDR_PAD, `DTC_IDX_IMASK}: rbyte = {6'h00, st_ff.imask};
				default:                         rhit = 1'b0;
			endcase
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = {24'h000000, rbyte};
			nxt_st.rresp  = rhit ? `DTC_RESP_OK : `DTC_RESP_SLVERR;
		end else if (st_ff.rvalid && axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Bus answers and interrupt outputs, all straight from the state
	always_comb begin
		axi_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
		axi_rsp.wready  = !st_ff.w_got && !st_ff.bvalid;
		axi_rsp.bresp   = st_ff.bresp;
		axi_rsp.bvalid  = st_ff.bvalid;
		axi_rsp.arready = !st_ff.rvalid;
		axi_rsp.rdata   = st_ff.rdata;
		axi_rsp.rresp   = st_ff.rresp;
		axi_rsp.rvalid  = st_ff.rvalid;
		ovf_req = {st_ff.timer_run_overflow_control[`DTC_TF1], st_ff.timer_run_overflow_control[`DTC_TF0]};
		irq     = |(st_ff.istat & st_ff.imask);
	end

	// Machine cycle repeats every twelve clocks
	property p_mc_period;
		@(posedge sys_clk) disable iff (srst)
		mc_tick |-> ##12 mc_tick;
	endproperty
	a_mc_period: assert property (p_mc_period) else $error("machine cycle period wrong");

	// Stopped timer 0 keeps its count
	property p_run_stop;
		@(posedge sys_clk) disable iff (srst)
		(!st_ff.timer_run_overflow_control[`DTC_TR0] && m0 != `DTC_MODE_SPLIT && !wr_cnt0)
			|=> $stable(st_ff.tl0) && $stable(st_ff.th0);
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("timer 0 moved while stopped");

	// Timer 1 in split mode holds
	property p_t1_hold;
		@(posedge sys_clk) disable iff (srst)
		(m1 == `DTC_MODE_SPLIT && !wr_cnt1) |=> $stable({st_ff.th1, st_ff.tl1});
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved in split mode");

	// Overflow raises the flag at the next edge
	property p_ovf_flag;
		@(posedge sys_clk) disable iff (srst)
		ovf0_ev |=> st_ff.timer_run_overflow_control[`DTC_TF0] && st_ff.istat[0];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	// Vectoring clears the flag unless a new overflow or write intervenes
	property p_ack_clear;
		@(posedge sys_clk) disable iff (srst)
		(int_ack[1] && !ovf1_ev && !wr_timer_run_overflow_control) |=> !ovf_req[1];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared on vector");

	// Auto reload copies the high byte
	property p_reload;
		@(posedge sys_clk) disable iff (srst)
		(m0 == `DTC_MODE_RLD && tick0 && st_ff.tl0 == 8'hff && !wr_cnt0)
			|=> st_ff.tl0 == $past(st_ff.th0) && st_ff.timer_run_overflow_control[`DTC_TF0];
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong");

	// Prescaler carry is the only way the high byte moves in mode 0
	property p_prescale;
		@(posedge sys_clk) disable iff (srst)
		(m0 == `DTC_MODE_13 && st_ff.tl0[4:0] != `DTC_PRE_MAX && !wr_cnt0)
			|=> $stable(st_ff.th0);
	endproperty
	a_prescale: assert property (p_prescale) else $error("high byte moved early");

	// Sixteen-bit carry into the high byte
	property p_cascade;
		@(posedge sys_clk) disable iff (srst)
		(m0 == `DTC_MODE_16 && tick0 && st_ff.tl0 == 8'hff && !wr_cnt0)
			|=> st_ff.th0 == $past(st_ff.th0) + 8'h01 && st_ff.tl0 == 8'h00;
	endproperty
	a_cascade: assert property (p_cascade) else $error("16-bit carry lost");

	// A closed gate freezes the low byte
	property p_gate;
		@(posedge sys_clk) disable iff (srst)
		(st_ff.timer_mode_select[`DTC_GATE] && !st_ff.gate_s2[0] && !wr_cnt0) |=> $stable(st_ff.tl0);
	endproperty
	a_gate: assert property (p_gate) else $error("timer 0 counted with gate closed");

	// Counter mode without an edge does not move
	property p_counter;
		@(posedge sys_clk) disable iff (srst)
		(st_ff.timer_mode_select[`DTC_SRC] && !fall[0] && m0 == `DTC_MODE_16 && !wr_cnt0)
			|=> $stable(st_ff.tl0);
	endproperty
	a_counter: assert property (p_counter) else $error("counter moved without edge");

	// Split high byte stops when timer 1 run bit is clear
	property p_split_hi;
		@(posedge sys_clk) disable iff (srst)
		(m0 == `DTC_MODE_SPLIT && !st_ff.timer_run_overflow_control[`DTC_TR1] && !wr_cnt0) |=> $stable(st_ff.th0);
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte ran");

endmodule

`default_nettype wire

// ===== verif/dtc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

// Outside signal source for the count and gate pins
module dtc_pin_model (
	input  wire logic             sys_clk,
	output var dtc_pkg::dtc_pin_s pins
);
	// Idle: count pins high, gates low, so the first pulse gives a clean falling edge
	initial pins = '{count_pin: 2'h3, ext_gate_pin: 2'h0};

	// Each level is held two machine cycles; count pins are sampled once per machine cycle, so one clock is not enough
	task automatic pulse(input int t, input int n);
		repeat (n) begin
			@(posedge sys_clk) pins.count_pin[t] <= 1'b0;
			repeat (24) @(posedge sys_clk);
			pins.count_pin[t] <= 1'b1;
			repeat (24) @(posedge sys_clk);
		end
	endtask

	// Gate level change, launched right after an edge
	task automatic gate(input int t, input logic v);
		@(posedge sys_clk) pins.ext_gate_pin[t] <= v;
	endtask
endmodule

`default_nettype wire

// ===== verif/dual_timer_counter_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtc_cfg.svh"

module dual_timer_counter_unit_bench;
	logic                  sys_clk;     // 100 MHz system clock
	logic                  srst;        // Synchronous reset
	dtc_pkg::dtc_axi_req_s axi_req;     // Bus master side
	dtc_pkg::dtc_axi_rsp_s axi_rsp;     // Bus slave answers
	dtc_pkg::dtc_pin_s     pins;        // Far-side pins
	logic [1:0]            int_ack;     // Vectoring pulses
	logic [1:0]            ovf_req;     // Overflow flags
	logic                  irq;         // Level interrupt
	int                    mismatches;  // Failed comparisons
	int                    checked;     // All comparisons
	logic [7:0]            rd;          // Last read byte
	logic [1:0]            rs;          // Last response code
	int                    t;           // Timer index
	int                    m;           // Mode index
	// Start high byte, then expected count bytes after one overflow, per mode 0..2
	logic [7:0]            th_init [3] = '{8'hff, 8'hff, 8'h80};
	logic [7:0]            tl_exp  [3] = '{8'he0, 8'h00, 8'h80};
	logic [7:0]            th_exp  [3] = '{8'h00, 8'h00, 8'h80};

	dtc_top u_dut (
		.sys_clk (sys_clk),
		.srst    (srst),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.pins    (pins),
		.int_ack (int_ack),
		.ovf_req (ovf_req),
		.irq     (irq)
	);

	dtc_pin_model u_pins (
		.sys_clk (sys_clk),
		.pins    (pins)
	);

	// Clock generator
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	// Comparison with counting
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bus write; each channel is released at the rising edge that takes it
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic b_hs;
		@(posedge sys_clk);
		axi_req.awaddr <= {`DTC_ADDR_PAD, idx, 2'h0};
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= {24'h0, d};
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs) begin
			@(posedge sys_clk);
			// Values seen here are those the edge sampled
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
			b_hs = axi_rsp.bvalid;
			rs = axi_rsp.bresp;
		end
		axi_req.bready <= 1'b0;
	endtask

	// Bus read into rd and rs
	task automatic rd_reg(input logic [7:0] idx);
		logic r_hs;
		@(posedge sys_clk);
		axi_req.araddr <= {`DTC_ADDR_PAD, idx, 2'h0};
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs) begin
			@(posedge sys_clk);
			// Read data taken at the edge that sees rvalid high
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
			r_hs = axi_rsp.rvalid;
			rd = axi_rsp.rdata[7:0];
			rs = axi_rsp.rresp;
		end
		axi_req.rready <= 1'b0;
	endtask

	// Read and compare one register
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		rd_reg(idx);
		check(what, exp, rd);
	endtask

	// Bounded wait for an overflow flag
	task automatic wait_flag(input int n, input int lim);
		int k;
		k = 0;
		while (ovf_req[n] !== 1'b1 && k < lim) begin
			@(negedge sys_clk);
			k++;
		end
		check("overflow flag", 8'h01, {7'h0, ovf_req[n]});
	endtask

	// One vectoring pulse; the flag must be gone after the sampling edge
	task automatic ack(input int n);
		@(posedge sys_clk) int_ack[n] <= 1'b1;
		@(posedge sys_clk) int_ack[n] <= 1'b0;
		@(negedge sys_clk);
		check("flag after ack", 8'h00, {7'h0, ovf_req[n]});
	endtask

	// Verdict, shared by the main sequence and the watchdog
	task automatic final_report;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		final_report();
	end

	// Main sequence
	initial begin
		mismatches = 0;
		checked = 0;
		srst = 1'b1;
		axi_req = '0;
		axi_req.wstrb = 4'hf;
		int_ack = 2'h0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		rchk(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h00, "control reset");
		rchk(`DTC_IDX_TIMER_MODE_SELECT, 8'h00, "mode reset");
		// Unmapped place in both directions
		rd_reg(8'h80);
		check("unmapped read resp", {6'h0, `DTC_RESP_SLVERR}, {6'h0, rs});
		wr(8'h80, 8'h00);
		check("unmapped write resp", {6'h0, `DTC_RESP_SLVERR}, {6'h0, rs});
		wr(`DTC_IDX_TIMER_MODE_SELECT, 8'ha5);
		rchk(`DTC_IDX_TIMER_MODE_SELECT, 8'ha5, "mode readback");
		wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h0f);
		rchk(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h0f, "control low nibble");
		wr(`DTC_IDX_IMASK, 8'h03);
		// Modes 0..2 on both timers, one overflow each
		for (t = 0; t < 2; t++) begin
			for (m = 0; m < 3; m++) begin
				wr(`DTC_IDX_TIMER_MODE_SELECT, 8'(m) << (4 * t));
				wr(`DTC_IDX_TL0 + t[7:0], 8'hff);
				wr(`DTC_IDX_TH0 + t[7:0], th_init[m]);
				repeat (30) @(posedge sys_clk);
				rchk(`DTC_IDX_TL0 + t[7:0], 8'hff, "count while stopped");
				wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h10 << (2 * t));
				wait_flag(t, 16);
				check("irq on overflow", 8'h01, {7'h0, irq});
				wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h00);
				rchk(`DTC_IDX_TL0 + t[7:0], tl_exp[m], "low byte");
				rchk(`DTC_IDX_TH0 + t[7:0], th_exp[m], "high byte");
				rchk(`DTC_IDX_ISTAT, 8'h01 << t, "event status");
				wr(`DTC_IDX_ISTAT, 8'h03);
				check("irq after clear", 8'h00, {7'h0, irq});
			end
		end
		// Gated counter on timer 0, interrupt masked
		wr(`DTC_IDX_IMASK, 8'h00);
		wr(`DTC_IDX_TIMER_MODE_SELECT, 8'h0d);
		wr(`DTC_IDX_TL0, 8'hfe);
		wr(`DTC_IDX_TH0, 8'hff);
		wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h10);
		u_pins.pulse(0, 3);
		rchk(`DTC_IDX_TL0, 8'hfe, "gate low count");
		u_pins.gate(0, 1'b1);
		u_pins.pulse(0, 1);
		rchk(`DTC_IDX_TL0, 8'hff, "pin event count");
		u_pins.pulse(0, 1);
		check("counter overflow", 8'h01, {7'h0, ovf_req[0]});
		check("masked irq", 8'h00, {7'h0, irq});
		ack(0);
		u_pins.gate(0, 1'b0);
		// Split mode: high byte on timer 1 run, timer 1 holds
		wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h00);
		wr(`DTC_IDX_TIMER_MODE_SELECT, 8'h33);
		wr(`DTC_IDX_TL0, 8'hff);
		wr(`DTC_IDX_TH0, 8'hff);
		wr(`DTC_IDX_TL1, 8'h55);
		wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h40);
		wait_flag(1, 16);
		check("t0 flag idle", 8'h00, {7'h0, ovf_req[0]});
		rchk(`DTC_IDX_TL0, 8'hff, "split low idle");
		rchk(`DTC_IDX_TL1, 8'h55, "timer 1 held");
		ack(1);
		wr(`DTC_IDX_TIMER_RUN_OVERFLOW_CONTROL, 8'h10);
		wait_flag(0, 16);
		check("t1 flag idle", 8'h00, {7'h0, ovf_req[1]});
		rchk(`DTC_IDX_TL0, 8'h00, "split low wrap");
		final_report();
	end
endmodule

`default_nettype wire
